/* File: shared/timer8_pkg.sv */
// package: register map, field layout and types of the 8-bit timer counter/compare unit
package timer8_pkg;

  // ******************************************
  // register byte addresses (one aligned word each)
  // ******************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00; // timer_control_reg
  localparam logic [7:0] ADDR_COUNT   = 8'h04; // count_value
  localparam logic [7:0] ADDR_COMPARE = 8'h08; // compare_value (buffer or active)
  localparam logic [7:0] ADDR_FLAGS   = 8'h0C; // overflow_flag, compare_flag, write one to clear
  localparam logic [7:0] ADDR_IRQEN   = 8'h10; // compare_irq_enable, overflow enable
  localparam logic [7:0] ADDR_STATUS  = 8'h14; // compare_output_latch, active compare, etc.

  // ******************************************
  // control register field positions
  // ******************************************
  localparam int CTL_CS_LSB    = 0; // tick_source_select [2:0]
  localparam int CTL_WGM0      = 3; // waveform_mode_field bit 0
  localparam int CTL_COM_LSB   = 4; // compare_output_mode [5:4]
  localparam int CTL_WGM1      = 6; // waveform_mode_field bit 1
  localparam int CTL_FOC       = 7; // force_compare_strobe, reads as zero
  localparam int FLG_OVF       = 0;
  localparam int FLG_CMP       = 1;
  localparam int STS_OC        = 0;
  localparam int STS_DIR_LSB   = 1;
  localparam int STS_ACT_LSB   = 8;

  // ******************************************
  // counter constants
  // ******************************************
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hFF;
  localparam logic [7:0] RESET_VAL  = 8'h00;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_SYS     = 3'h1; // tick every cycle
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // waveform modes in field encoding
  typedef enum logic [1:0] {
    WM_NORMAL = 2'h0,
    WM_PC_PWM = 2'h1,
    WM_CTC    = 2'h2,
    WM_FAST   = 2'h3
  } wave_mode_e;

  // control fields carried together
  typedef struct packed {
    logic [1:0] com;
    wave_mode_e wgm;
    logic [2:0] cs;
  } ctl_s;

endpackage : timer8_pkg

/* File: design/timer8_counter_compare_unit.sv */
// module: counter, comparator and compare output latch of the 8-bit timer, AXI4-Lite slave
// Function
// - clock select zero stops all ticks
// - each tick clears, increments or decrements count
// - cpu reads and writes count anytime
// - cpu count write beats count/clear
// - two-bit waveform field picks sequence
// - overflow flag per mode, interrupt source
// - match sets compare flag next tick
// - compare irq needs flag, enable, global
// - compare flag cleared by service or write-one
// - max and bottom indications for generator
// - double buffer compare only in pwm
// - buffer copies at top or bottom only
// - cpu reaches buffer or active register
// - force strobe acts as match, non-pwm
// - forced match sets no flag, no clear
// - count write blocks next tick's match, except the ctc clear
// - latch kept across waveform mode changes
// - output mode not buffered, acts immediately
// - reset clears compare output latch
// - nonzero output mode routes latch to pin
// - output mode zero leaves latch untouched
// - mode codes normal0 pc1 ctc2 fast3
// - bottom 00, max FF, top by mode
// - normal mode wraps, overflow at zero
`timescale 1ns/1ps
module timer8_counter_compare_unit
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // tick sources
  input  wire logic        prescale_tick,
  input  wire logic        ext_clk_pin,
  // interrupt handshake with the cpu
  input  wire logic        global_irq_enable,
  input  wire logic        compare_irq_ack,
  input  wire logic        overflow_irq_ack,
  output logic             compare_irq,
  output logic             overflow_irq,
  // compare pin
  input  wire logic        compare_pin_direction,
  input  wire logic        port_data,
  output logic             compare_pin_out,
  output logic             compare_pin_oe_n,
  // waveform generator indications
  output logic             count_at_max,
  output logic             count_at_bottom
);

  // ******************************************
  // state
  // ******************************************
  timer8_pkg::ctl_s ctl_q;
  logic [7:0]  count_value_q;
  logic [7:0]  compare_value_q;   // active compare register
  logic [7:0]  compare_buf_q;     // buffer register
  logic        overflow_flag_q;
  logic        compare_flag_q;
  logic        compare_irq_enable_q;
  logic        overflow_irq_enable_q;
  logic        compare_output_latch_q;
  logic        count_down_q;
  logic        block_q;           // a count write blocks the next tick's match
  logic [2:0]  ext_sync_q;        // two-stage sync plus edge history

  // ******************************************
  // bus slave handshake
  // ******************************************
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        write_err;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire         wr_fire  = aw_held_q && w_held_q && !s_axi_bvalid;
  wire         wr_lane0 = wr_fire && wstrb_q[0];
  wire         wr_ctl   = wr_lane0 && (awaddr_q == timer8_pkg::ADDR_CONTROL);
  wire         wr_cnt   = wr_lane0 && (awaddr_q == timer8_pkg::ADDR_COUNT);
  wire         wr_cmp   = wr_lane0 && (awaddr_q == timer8_pkg::ADDR_COMPARE);
  wire         wr_flg   = wr_lane0 && (awaddr_q == timer8_pkg::ADDR_FLAGS);
  wire         wr_ien   = wr_lane0 && (awaddr_q == timer8_pkg::ADDR_IRQEN);

  // known address check, used by both channels
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == timer8_pkg::ADDR_CONTROL) || (a == timer8_pkg::ADDR_COUNT) ||
                 (a == timer8_pkg::ADDR_COMPARE) || (a == timer8_pkg::ADDR_FLAGS) ||
                 (a == timer8_pkg::ADDR_IRQEN)   || (a == timer8_pkg::ADDR_STATUS);
  endfunction : addr_known

  assign write_err = !addr_known(awaddr_q) || (awaddr_q == timer8_pkg::ADDR_STATUS);

  // address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= timer8_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_err ? timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ******************************************
  // tick generation
  // ******************************************
  wire ext_rise = ext_sync_q[1] && !ext_sync_q[2];
  wire ext_fall = !ext_sync_q[1] && ext_sync_q[2];
  logic timer_tick;

  // stopped select gives no tick from any source
  always_comb
  begin
    unique case (ctl_q.cs)
      timer8_pkg::CS_STOP:     timer_tick = 1'b0;
      timer8_pkg::CS_SYS:      timer_tick = 1'b1;
      timer8_pkg::CS_EXT_FALL: timer_tick = ext_fall;
      timer8_pkg::CS_EXT_RISE: timer_tick = ext_rise;
      default:                 timer_tick = prescale_tick;
    endcase
  end

  // pin sync, first stage read only by the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_sync_q <= 3'h0;
    else
      ext_sync_q <= {ext_sync_q[1], ext_sync_q[0], ext_clk_pin};
  end

  // ******************************************
  // counter and comparator decode
  // ******************************************
  wire is_pwm   = (ctl_q.wgm == timer8_pkg::WM_PC_PWM) || (ctl_q.wgm == timer8_pkg::WM_FAST);
  wire is_ctc   = (ctl_q.wgm == timer8_pkg::WM_CTC);
  wire raw_match = (count_value_q == compare_value_q);
  wire match_ok = raw_match && !block_q;
  assign count_at_max    = (count_value_q == timer8_pkg::MAX_VAL);
  assign count_at_bottom = (count_value_q == timer8_pkg::BOTTOM_VAL);
  wire ctc_clear = is_ctc && raw_match;
  wire pc_turn_down = (ctl_q.wgm == timer8_pkg::WM_PC_PWM) && !count_down_q && count_at_max;
  wire pc_turn_up   = (ctl_q.wgm == timer8_pkg::WM_PC_PWM) && count_down_q && count_at_bottom;
  wire going_down   = (ctl_q.wgm == timer8_pkg::WM_PC_PWM) && (pc_turn_down || (count_down_q && !pc_turn_up));
  logic [7:0] count_next;
  logic       ovf_event;

  // next count per waveform mode
  always_comb
  begin
    count_next = count_value_q + 8'h01;
    ovf_event  = 1'b0;
    unique case (ctl_q.wgm)
      timer8_pkg::WM_NORMAL:
        ovf_event = count_at_max;
      timer8_pkg::WM_CTC:
      begin
        if (ctc_clear)
          count_next = timer8_pkg::BOTTOM_VAL;
        ovf_event = count_at_max;
      end
      timer8_pkg::WM_FAST:
        ovf_event = count_at_max;
      timer8_pkg::WM_PC_PWM:
      begin
        if (going_down)
          count_next = count_value_q - 8'h01;
        ovf_event = pc_turn_up;
      end
    endcase
  end

  // buffered copy at top (fast) or bottom (phase correct)
  wire buf_load = timer_tick && ((ctl_q.wgm == timer8_pkg::WM_FAST && count_at_max) ||
                                 (ctl_q.wgm == timer8_pkg::WM_PC_PWM && count_at_bottom));

  // ******************************************
  // output latch action
  // ******************************************
  wire force_hit = wr_ctl && wdata_q[timer8_pkg::CTL_FOC] && !is_pwm;
  wire tick_hit  = timer_tick && match_ok;
  logic latch_next;

  // com field governs the next match; zero means no action
  always_comb
  begin
    latch_next = compare_output_latch_q;
    if (ctl_q.com != 2'h0)
    begin
      if (!is_pwm && (force_hit || tick_hit))
        latch_next = (ctl_q.com == 2'h1) ? !compare_output_latch_q : ctl_q.com[0];
      else if (ctl_q.wgm == timer8_pkg::WM_FAST && timer_tick && count_at_max)
        latch_next = ctl_q.com[0] ? 1'b0 : 1'b1;
      else if (is_pwm && tick_hit)
        latch_next = ctl_q.com[0] ^ (ctl_q.wgm == timer8_pkg::WM_PC_PWM && going_down) ? 1'b1 : 1'b0;
    end
  end

  // ******************************************
  // core state
  // ******************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q                  <= '0;
      count_value_q          <= timer8_pkg::RESET_VAL;
      compare_value_q        <= timer8_pkg::RESET_VAL;
      compare_buf_q          <= timer8_pkg::RESET_VAL;
      overflow_flag_q        <= 1'b0;
      compare_flag_q         <= 1'b0;
      compare_irq_enable_q   <= 1'b0;
      overflow_irq_enable_q  <= 1'b0;
      compare_output_latch_q <= 1'b0;
      count_down_q           <= 1'b0;
      block_q                <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ctl_q <= timer8_pkg::ctl_s'({wdata_q[timer8_pkg::CTL_COM_LSB +: 2], wdata_q[timer8_pkg::CTL_WGM1],
                                     wdata_q[timer8_pkg::CTL_WGM0], wdata_q[timer8_pkg::CTL_CS_LSB +: 3]});
      compare_output_latch_q <= latch_next;
      if (wr_cnt)
        count_value_q <= wdata_q[7:0];
      else if (timer_tick)
        count_value_q <= count_next;
      if (timer_tick)
        count_down_q <= going_down;
      if (wr_cnt)
        block_q <= 1'b1;
      else if (timer_tick)
        block_q <= 1'b0;
      if (wr_cmp && !is_pwm)
        compare_value_q <= wdata_q[7:0];
      else if (buf_load || !is_pwm)
        compare_value_q <= is_pwm ? compare_buf_q : compare_value_q;
      if (wr_cmp)
        compare_buf_q <= wdata_q[7:0];
      // set wins over clear; a forced match never reaches the flag
      if (tick_hit)
        compare_flag_q <= 1'b1;
      else if (compare_irq_ack || (wr_flg && wdata_q[timer8_pkg::FLG_CMP]))
        compare_flag_q <= 1'b0;
      if (timer_tick && ovf_event)
        overflow_flag_q <= 1'b1;
      else if (overflow_irq_ack || (wr_flg && wdata_q[timer8_pkg::FLG_OVF]))
        overflow_flag_q <= 1'b0;
      if (wr_ien)
      begin
        compare_irq_enable_q  <= wdata_q[timer8_pkg::FLG_CMP];
        overflow_irq_enable_q <= wdata_q[timer8_pkg::FLG_OVF];
      end
    end
  end

  assign compare_irq  = compare_flag_q && compare_irq_enable_q && global_irq_enable;
  assign overflow_irq = overflow_flag_q && overflow_irq_enable_q && global_irq_enable;

  // pin override independent of mode; direction still gates output
  assign compare_pin_out  = (ctl_q.com != 2'h0) ? compare_output_latch_q : port_data;
  assign compare_pin_oe_n = !compare_pin_direction;

  // ******************************************
  // read channel
  // ******************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      timer8_pkg::ADDR_CONTROL: rd_mux[7:0] = {1'b0, ctl_q.wgm[1], ctl_q.com, ctl_q.wgm[0], ctl_q.cs};
      timer8_pkg::ADDR_COUNT:   rd_mux[7:0] = count_value_q;
      timer8_pkg::ADDR_COMPARE: rd_mux[7:0] = is_pwm ? compare_buf_q : compare_value_q;
      timer8_pkg::ADDR_FLAGS:   rd_mux[1:0] = {compare_flag_q, overflow_flag_q};
      timer8_pkg::ADDR_IRQEN:   rd_mux[1:0] = {compare_irq_enable_q, overflow_irq_enable_q};
      timer8_pkg::ADDR_STATUS:  rd_mux[15:0] = {compare_value_q, 5'h00, count_down_q,
                                                compare_pin_direction, compare_output_latch_q};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= timer8_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= addr_known(s_axi_araddr) ? timer8_pkg::RESP_OKAY : timer8_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ******************************************
  // assertions
  // ******************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_stop;
    (ctl_q.cs == timer8_pkg::CS_STOP) && !wr_cnt |=> $stable(count_value_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");
  property p_write_wins;
    wr_cnt |=> count_value_q == $past(wdata_q[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");
  sequence s_match_tick;
    timer_tick && match_ok;
  endsequence
  property p_flag;
    s_match_tick |=> compare_flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("compare flag not set");
  property p_irq;
    compare_irq == (compare_flag_q && compare_irq_enable_q && global_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("compare irq gating wrong");
  property p_block;
    timer_tick && block_q && !compare_flag_q |=> !compare_flag_q;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  property p_force_no_flag;
    force_hit && !timer_tick && !compare_irq_ack |=> $stable(compare_flag_q) && $stable(count_value_q);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force changed flag or count");
  property p_com_zero;
    (ctl_q.com == 2'h0) |=> $stable(compare_output_latch_q);
  endproperty
  a_com_zero: assert property (p_com_zero) else $error("latch moved with output mode zero");
  property p_ovf;
    timer_tick && !wr_cnt && (ctl_q.wgm == timer8_pkg::WM_NORMAL) && count_at_max
      |=> overflow_flag_q && count_value_q == timer8_pkg::BOTTOM_VAL;
  endproperty
  a_ovf: assert property (p_ovf) else $error("normal wrap without overflow");

endmodule : timer8_counter_compare_unit

/* File: verif/cpu_pin_model.sv */
// cpu-side partner: interrupt servicing and the resolved compare pin wire
`timescale 1ns/1ps
module cpu_pin_model
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // interrupt service
  input  wire logic service_en,
  input  wire logic compare_irq,
  output logic      compare_irq_ack,
  // pin wire
  input  wire logic compare_pin_out,
  input  wire logic compare_pin_oe_n,
  output logic      pin_level
);
  logic [1:0] wait_q;
  logic       last_q;

  // ack pulse after a vector fetch latency; guard stops a second ack
  always_ff @(posedge aclk)
  begin
    compare_irq_ack <= 1'b0;
    wait_q          <= 2'h0;
    if (aresetn && service_en && compare_irq && !compare_irq_ack)
    begin
      wait_q          <= wait_q + 2'h1;
      compare_irq_ack <= (wait_q == 2'h3);
    end
  end

  // released pin shows the inverse of its last level, never a stale copy
  always_ff @(posedge aclk)
  begin
    if (!compare_pin_oe_n)
      last_q <= compare_pin_out;
  end
  assign pin_level = compare_pin_oe_n ? ~last_q : compare_pin_out;
endmodule : cpu_pin_model

/* File: verif/timer8_counter_compare_unit_bench.sv */
// self-checking bench of the timer counter/compare unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module timer8_counter_compare_unit_bench;
  typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} note_s;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, prescale_tick;
  logic        ext_clk_pin, global_irq_enable, compare_irq_ack, compare_irq, overflow_irq, port_data;
  logic        compare_pin_direction, compare_pin_out, compare_pin_oe_n, count_at_max, count_at_bottom;
  logic        service_en, pin_level;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, s;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errors, n_tests, cyc, n;
  note_s       rq[$];
  note_s       cur;
  logic [1:0]  bq[$];

  // ******************************************
  // design, partner, clock
  // ******************************************
  timer8_counter_compare_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .prescale_tick, .ext_clk_pin, .global_irq_enable, .compare_irq_ack,
    .overflow_irq_ack(1'b0), .compare_irq, .overflow_irq, .compare_pin_direction, .port_data,
    .compare_pin_out, .compare_pin_oe_n, .count_at_max, .count_at_bottom);
  cpu_pin_model u_cpu (.aclk, .aresetn, .service_en, .compare_irq, .compare_irq_ack,
    .compare_pin_out, .compare_pin_oe_n, .pin_level);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ******************************************
  // bus tasks and result monitor
  // ******************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic b;
    bq.push_back(r);
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFF,
                    input logic [1:0] r = 2'h0);
    logic b;
    rq.push_back('{e, m, r});
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!b)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      b = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  // one-cycle prescaler enables, spaced by an idle cycle
  task automatic tick(input int k);
    repeat (k)
    begin
      @(posedge aclk);
      prescale_tick <= 1'b1;
      @(posedge aclk);
      prescale_tick <= 1'b0;
    end
  endtask : tick

  // slow pin edges so the synchroniser sees every one
  task automatic ext4();
    repeat (4)
    begin
      repeat (4) @(posedge aclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clk_pin <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask : ext4

  task automatic end_sim();
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // oldest note meets each bus answer
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      cur = rq.pop_front();
      `CHK("rdata", cur.v & cur.m, s_axi_rdata & cur.m)
      `CHK("rresp", cur.r, s_axi_rresp)
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      cur.r = bq.pop_front();
      `CHK("bresp", cur.r, s_axi_bresp)
    end
  end

  // hang guard, generous against a run of well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      end_sim();
    end
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {prescale_tick, ext_clk_pin, global_irq_enable, compare_pin_direction, port_data, service_en} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    n = $urandom(32'he6f45af9);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(timer8_pkg::ADDR_CONTROL, 32'h0);
    rd(timer8_pkg::ADDR_COUNT, 32'h0);
    rd(timer8_pkg::ADDR_COMPARE, 32'h0);
    rd(timer8_pkg::ADDR_STATUS, 32'h0, 32'h1);
    wr(8'h18, 32'h1, timer8_pkg::RESP_SLVERR);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, timer8_pkg::RESP_SLVERR);
    // random start kept clear of the compare value zero
    s = 8'h40 + 8'($urandom % 64);
    n = 1 + $urandom % 8;
    wr(timer8_pkg::ADDR_COUNT, {24'h0, s});
    wr(timer8_pkg::ADDR_CONTROL, 32'h2);
    tick(n);
    rd(timer8_pkg::ADDR_COUNT, {24'h0, s + 8'(n)});
    wr(timer8_pkg::ADDR_CONTROL, 32'h0);
    tick(3);
    ext4();
    rd(timer8_pkg::ADDR_COUNT, {24'h0, s + 8'(n)});
    wr(timer8_pkg::ADDR_CONTROL, 32'h7);
    ext4();
    rd(timer8_pkg::ADDR_COUNT, {24'h0, s + 8'(n + 4)});
    wr(timer8_pkg::ADDR_CONTROL, 32'h6);
    ext4();
    rd(timer8_pkg::ADDR_COUNT, {24'h0, s + 8'(n + 8)});
    wr(timer8_pkg::ADDR_CONTROL, 32'h2);
    // wrap past the maximum in normal mode
    wr(timer8_pkg::ADDR_COUNT, 32'hFF);
    `CHK("count_at_max", 1'b1, count_at_max)
    wr(timer8_pkg::ADDR_COUNT, 32'hFE);
    wr(timer8_pkg::ADDR_FLAGS, 32'h3);
    tick(1);
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h1);
    tick(1);
    rd(timer8_pkg::ADDR_FLAGS, 32'h1, 32'h1);
    rd(timer8_pkg::ADDR_COUNT, 32'h0);
    `CHK("count_at_bottom", 1'b1, count_at_bottom)
    // match, flag one tick later, interrupt gating and service
    wr(timer8_pkg::ADDR_COMPARE, 32'h27);
    wr(timer8_pkg::ADDR_COUNT, 32'h24);
    wr(timer8_pkg::ADDR_FLAGS, 32'h3);
    tick(3);
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h2);
    tick(1);
    rd(timer8_pkg::ADDR_FLAGS, 32'h2, 32'h2);
    wr(timer8_pkg::ADDR_IRQEN, 32'h2);
    global_irq_enable <= 1'b1;
    @(posedge aclk);
    `CHK("compare_irq", 1'b1, compare_irq)
    global_irq_enable <= 1'b0;
    @(posedge aclk);
    `CHK("compare_irq", 1'b0, compare_irq)
    global_irq_enable <= 1'b1;
    service_en <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK("compare_irq", 1'b0, compare_irq)
    service_en <= 1'b0;
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h2);
    wr(timer8_pkg::ADDR_COUNT, 32'h26);
    tick(2);
    rd(timer8_pkg::ADDR_FLAGS, 32'h2, 32'h2);
    wr(timer8_pkg::ADDR_FLAGS, 32'h2);
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h2);
    // a count write equal to compare loses that match
    wr(timer8_pkg::ADDR_COMPARE, 32'h30);
    wr(timer8_pkg::ADDR_COUNT, 32'h30);
    tick(2);
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h2);
    // forced toggle while stopped, then pin routing
    wr(timer8_pkg::ADDR_CONTROL, 32'h10);
    compare_pin_direction <= 1'b1;
    wr(timer8_pkg::ADDR_CONTROL, 32'h90);
    rd(timer8_pkg::ADDR_STATUS, 32'h1, 32'h1);
    rd(timer8_pkg::ADDR_FLAGS, 32'h0, 32'h2);
    rd(timer8_pkg::ADDR_COUNT, 32'h32);
    `CHK("pin_level", 1'b1, pin_level)
    wr(timer8_pkg::ADDR_CONTROL, 32'h0);
    wr(timer8_pkg::ADDR_CONTROL, 32'h80);
    rd(timer8_pkg::ADDR_STATUS, 32'h1, 32'h1);
    `CHK("compare_pin_out", 1'b0, compare_pin_out)
    compare_pin_direction <= 1'b0;
    @(posedge aclk);
    `CHK("compare_pin_oe_n", 1'b1, compare_pin_oe_n)
    // fast pwm: buffered compare lands at the top only
    wr(timer8_pkg::ADDR_CONTROL, 32'h48);
    rd(timer8_pkg::ADDR_STATUS, 32'h1, 32'h1);
    wr(timer8_pkg::ADDR_COUNT, 32'hFD);
    wr(timer8_pkg::ADDR_COMPARE, 32'h40);
    rd(timer8_pkg::ADDR_COMPARE, 32'h40);
    rd(timer8_pkg::ADDR_STATUS, 32'h3000, 32'hFF00);
    wr(timer8_pkg::ADDR_FLAGS, 32'h3);
    wr(timer8_pkg::ADDR_CONTROL, 32'h4A);
    tick(1);
    rd(timer8_pkg::ADDR_STATUS, 32'h3000, 32'hFF00);
    tick(3);
    rd(timer8_pkg::ADDR_STATUS, 32'h4000, 32'hFF00);
    rd(timer8_pkg::ADDR_FLAGS, 32'h1, 32'h1);
    wr(timer8_pkg::ADDR_IRQEN, 32'h3);
    `CHK("overflow_irq", 1'b1, overflow_irq)
    // phase correct turns at the maximum, clear-on-match wraps at compare
    wr(timer8_pkg::ADDR_CONTROL, 32'h0A);
    wr(timer8_pkg::ADDR_COUNT, 32'hFE);
    tick(2);
    rd(timer8_pkg::ADDR_COUNT, 32'hFE);
    wr(timer8_pkg::ADDR_CONTROL, 32'h42);
    wr(timer8_pkg::ADDR_COMPARE, 32'h05);
    rd(timer8_pkg::ADDR_STATUS, 32'h0500, 32'hFF00);
    wr(timer8_pkg::ADDR_COUNT, 32'h03);
    tick(3);
    rd(timer8_pkg::ADDR_COUNT, 32'h0);
    repeat (2) @(posedge aclk);
    end_sim();
  end
endmodule : timer8_counter_compare_unit_bench
